// ---- hw/asr_consts.svh ----
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

// register byte offsets
`define ASR_OFS_BAUD 8'h00
`define ASR_OFS_CTRL 8'h04
`define ASR_OFS_STAT 8'h08
`define ASR_OFS_DATA 8'h0C

// reset values and write masks
`define ASR_BAUD_RST 13'h0001
`define ASR_CTRL_RST 8'h00
`define ASR_CTRL_MASK 8'h3D

// frame lengths in bit times, last bit index
`define ASR_FRAME8 4'hA
`define ASR_FRAME9 4'hB
`define ASR_LAST8 4'h9
`define ASR_LAST9 4'hA

// sample slots, stored as slot number minus one
`define ASR_RT3 4'h2
`define ASR_RT5 4'h4
`define ASR_RT7 4'h6
`define ASR_RT8 4'h7
`define ASR_RT9 4'h8
`define ASR_RT10 4'h9
`define ASR_RT16 4'hF

`endif

// ---- hw/asr_core.sv ----
// Summary of operation
// - enabling transmitter queues one idle preamble frame
// - shifter is 10 bits, 11 in nine-bit
// - free shifter takes buffered char, buffer empty set
// - nothing buffered after stop: done flag, line high
// - disabling waits for data, idle, break frames
// - break is full frame of low level
// - break bit queues break, requeues while high
// - enable low-high queues idle, keeps pin
// - start low, data LSB first, stop high
// - stop received and buffer free: store, full
// - full buffer: overrun set, new char dropped
// - full flag clears only by access sequence
// - status read while full, then data read
// - receiver samples sixteen slots per bit
// - edge is low after three highs
// - start valid if two of slots 3,5,7 low
// - bits decided by majority of slots 8-10
// - valid start bit always taken as low
// - any disagreeing sample sets glitch flag on store
// - an edge after three highs resyncs slots, but not during start check
// - non-break framing error preloads three highs
// - frame-bad flag set blocks buffer transfers
// - break received as zero data, frame bad
// - error flags set with full flag, not overrun
// - ninth tx bit copied with data byte
//
// Added by the designer: the address map and register access over APB.
`include "asr_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module asr_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutEn
);

////////////////////////////////////////////////////////////////////////////
// reset release

logic [1:0] rstSync_q;
logic rstN;

always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        rstSync_q <= 2'h0;
    end else begin
        rstSync_q <= {rstSync_q[0], 1'b1};
    end
end

assign rstN = rstSync_q[1];

////////////////////////////////////////////////////////////////////////////
// apb slave, one wait state on every access

logic pready_q;
logic pslverr_q;
logic [31:0] prdata_q;
logic accStart;
logic accDone;
logic mapped;
logic wrBaud;
logic wrCtrl;
logic wrData;
logic rdStat;
logic rdData;
logic [31:0] readVal;
logic [12:0] baud_q;
asr_pkg::asr_ctrl_t ctrl_q;
asr_pkg::asr_stat_t stat;
logic [7:0] rxData_q;

assign accStart = psel & penable & ~pready_q;
assign accDone = psel & penable & pready_q;
assign mapped = (paddr == `ASR_OFS_BAUD) || (paddr == `ASR_OFS_CTRL) ||
                (paddr == `ASR_OFS_STAT) || (paddr == `ASR_OFS_DATA);
assign wrBaud = accDone & pwrite & (paddr == `ASR_OFS_BAUD);
assign wrCtrl = accDone & pwrite & (paddr == `ASR_OFS_CTRL);
assign wrData = accDone & pwrite & (paddr == `ASR_OFS_DATA);
assign rdStat = accDone & ~pwrite & (paddr == `ASR_OFS_STAT);
assign rdData = accDone & ~pwrite & (paddr == `ASR_OFS_DATA);

always_comb begin
    case (paddr)
        `ASR_OFS_BAUD: readVal = {19'h0, baud_q};
        `ASR_OFS_CTRL: readVal = {24'h0, ctrl_q};
        `ASR_OFS_STAT: readVal = {24'h0, stat};
        `ASR_OFS_DATA: readVal = {24'h0, rxData_q};
        default: readVal = 32'h0;
    endcase
end

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0;
    end else begin
        pready_q <= accStart;
        pslverr_q <= accStart & ~mapped;
        if (accStart && !pwrite) begin
            prdata_q <= readVal;
        end
    end
end

assign pready = pready_q;
assign pslverr = pslverr_q;
assign prdata = prdata_q;

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        baud_q <= `ASR_BAUD_RST;
        ctrl_q <= `ASR_CTRL_RST;
    end else begin
        if (wrBaud) begin
            baud_q <= pwdata[12:0];
        end
        if (wrCtrl) begin
            ctrl_q <= asr_pkg::asr_ctrl_t'(pwdata[7:0] & `ASR_CTRL_MASK);
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// sixteen-times bit clock, shared by both directions

logic [12:0] presc_q;
logic rtTick;

assign rtTick = (presc_q == 13'h0000);

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        presc_q <= 13'h0000;
    end else if (rtTick) begin
        // divisor zero behaves as one: tick every clock
        presc_q <= (baud_q == 13'h0000) ? 13'h0000 : baud_q - 13'h0001;
    end else begin
        presc_q <= presc_q - 13'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////
// transmitter

asr_pkg::asr_tx_state_t txState_q;
logic [3:0] txPhase_q;
logic [3:0] txLeft_q;
logic [10:0] txShift_q;
logic [7:0] txBuf_q;
logic txBufFull_q;
logic txDone_q;
logic idleQ_q;
logic breakQ_q;
logic txOnPrev_q;
logic brkPrev_q;
logic txOut_q;
logic txEn_q;
logic bitTick;
logic txSlot;
logic loadBrk;
logic loadIdle;
logic loadData;
logic loadAny;
logic txOnRise;
logic brkRise;
logic [3:0] txLen;

assign bitTick = rtTick & (txPhase_q == `ASR_RT16);
assign txSlot = bitTick & ((txState_q == asr_pkg::TX_IDLE) ||
                ((txState_q == asr_pkg::TX_SHIFT) && (txLeft_q == 4'h1)));
assign loadBrk = txSlot & breakQ_q;
assign loadIdle = txSlot & ~breakQ_q & idleQ_q;
assign loadData = txSlot & ~breakQ_q & ~idleQ_q & txBufFull_q & ctrl_q.txOn;
assign loadAny = loadBrk | loadIdle | loadData;
assign txOnRise = ctrl_q.txOn & ~txOnPrev_q;
assign brkRise = ctrl_q.breakQueueBit & ~brkPrev_q;
assign txLen = ctrl_q.nineBit ? `ASR_FRAME9 : `ASR_FRAME8;

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        txPhase_q <= 4'h0;
        txOnPrev_q <= 1'b0;
        brkPrev_q <= 1'b0;
    end else begin
        txPhase_q <= rtTick ? txPhase_q + 4'h1 : txPhase_q;
        txOnPrev_q <= ctrl_q.txOn;
        brkPrev_q <= ctrl_q.breakQueueBit;
    end
end

// queued preamble, idle and break frames
always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        idleQ_q <= 1'b0;
        breakQ_q <= 1'b0;
    end else begin
        if (loadIdle) begin
            idleQ_q <= 1'b0;
        end
        if (txOnRise) begin
            idleQ_q <= 1'b1;
        end
        if (loadBrk) begin
            breakQ_q <= ctrl_q.breakQueueBit;
        end
        if (brkRise) begin
            breakQ_q <= 1'b1;
        end
    end
end

// buffer and flags; a set in the same cycle beats a clear
always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        txBuf_q <= 8'h00;
        txBufFull_q <= 1'b0;
        txDone_q <= 1'b1;
    end else begin
        if (loadData) begin
            txBufFull_q <= 1'b0;
        end
        if (wrData) begin
            txBuf_q <= pwdata[7:0];
            txBufFull_q <= 1'b1;
        end
        if (wrData || txOnRise || brkRise) begin
            txDone_q <= 1'b0;
        end
        if (txSlot && (txState_q == asr_pkg::TX_SHIFT) && !loadAny) begin
            txDone_q <= 1'b1;
        end
    end
end

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        txState_q <= asr_pkg::TX_OFF;
    end else begin
        case (txState_q)
            asr_pkg::TX_OFF: begin
                if (ctrl_q.txOn) begin
                    txState_q <= asr_pkg::TX_IDLE;
                end
            end
            asr_pkg::TX_IDLE: begin
                if (loadAny) begin
                    txState_q <= asr_pkg::TX_SHIFT;
                end else if (bitTick && !ctrl_q.txOn) begin
                    txState_q <= asr_pkg::TX_OFF;
                end
            end
            asr_pkg::TX_SHIFT: begin
                // pin held until the frame and any queued idle or break frames end
                if (txSlot && !loadAny) begin
                    txState_q <= ctrl_q.txOn ? asr_pkg::TX_IDLE
                                             : asr_pkg::TX_OFF;
                end
            end
            default: begin
                txState_q <= asr_pkg::TX_OFF;
            end
        endcase
    end
end

// frame loads happen only on bit boundaries of the shared bit clock
always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        txShift_q <= 11'h7FF;
        txLeft_q <= 4'h0;
    end else if (loadBrk) begin
        txShift_q <= 11'h000;
        txLeft_q <= txLen;
    end else if (loadIdle) begin
        txShift_q <= 11'h7FF;
        txLeft_q <= txLen;
    end else if (loadData) begin
        // unused ninth-bit slot carries the stop in eight-bit mode
        txShift_q <= {1'b1, ctrl_q.nineBit ? ctrl_q.txNinthBit : 1'b1,
                      txBuf_q, 1'b0};
        txLeft_q <= txLen;
    end else if (bitTick && (txState_q == asr_pkg::TX_SHIFT)) begin
        txShift_q <= {1'b1, txShift_q[10:1]};
        txLeft_q <= txLeft_q - 4'h1;
    end
end

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        txOut_q <= 1'b1;
        txEn_q <= 1'b0;
    end else begin
        txOut_q <= (txState_q == asr_pkg::TX_SHIFT) ? txShift_q[0] : 1'b1;
        txEn_q <= (txState_q != asr_pkg::TX_OFF);
    end
end

assign serialOutPin = txOut_q;
assign serialOutEn = txEn_q;

////////////////////////////////////////////////////////////////////////////
// receiver

asr_pkg::asr_rx_state_t rxState_q;
logic rxPin_q;
logic [2:0] hist_q;
logic [3:0] rt_q;
logic [3:0] bitIdx_q;
logic [1:0] lowCnt_q;
logic [1:0] onesCnt_q;
logic noise_q;
logic [8:0] rxShift_q;
logic edgeSeen;
logic [1:0] onesTot;
logic [1:0] lowTot;
logic majority;
logic disagree;
logic [3:0] lastIdx;
logic rxDone;
logic stopLow;
logic [7:0] frameData;
logic frameNinth;
logic isBreak;

assign edgeSeen = rtTick & (hist_q == 3'h7) & ~rxPin_q;
assign onesTot = onesCnt_q + {1'b0, rxPin_q};
assign lowTot = lowCnt_q + {1'b0, ~rxPin_q};
assign majority = onesTot[1];
assign disagree = (onesTot != 2'h0) && (onesTot != 2'h3);
assign lastIdx = ctrl_q.nineBit ? `ASR_LAST9 : `ASR_LAST8;
assign rxDone = rtTick & (rxState_q == asr_pkg::RX_BITS) &
                (rt_q == `ASR_RT10) & (bitIdx_q == lastIdx);
assign stopLow = ~majority;
assign frameData = ctrl_q.nineBit ? rxShift_q[7:0] : rxShift_q[8:1];
assign frameNinth = ctrl_q.nineBit & rxShift_q[8];
assign isBreak = (frameData == 8'h00) & ~frameNinth & stopLow;

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        rxPin_q <= 1'b1;
        hist_q <= 3'h0;
    end else begin
        rxPin_q <= serialInPin;
        if (rxDone && stopLow && !isBreak) begin
            hist_q <= 3'h7;
        end else if (rtTick) begin
            hist_q <= {hist_q[1:0], rxPin_q};
        end
    end
end

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        rxState_q <= asr_pkg::RX_IDLE;
        rt_q <= 4'h0;
        bitIdx_q <= 4'h0;
        lowCnt_q <= 2'h0;
        onesCnt_q <= 2'h0;
        noise_q <= 1'b0;
        rxShift_q <= 9'h000;
    end else if (!ctrl_q.rxOn) begin
        rxState_q <= asr_pkg::RX_IDLE;
    end else if (rtTick) begin
        case (rxState_q)
            asr_pkg::RX_IDLE: begin
                if (edgeSeen) begin
                    rxState_q <= asr_pkg::RX_START;
                    rt_q <= 4'h0;
                    bitIdx_q <= 4'h0;
                    lowCnt_q <= 2'h0;
                    onesCnt_q <= 2'h0;
                    noise_q <= 1'b0;
                end
            end
            asr_pkg::RX_START: begin
                rt_q <= rt_q + 4'h1;
                if ((rt_q == `ASR_RT3) || (rt_q == `ASR_RT5)) begin
                    lowCnt_q <= lowTot;
                end
                if (rt_q == `ASR_RT7) begin
                    if (lowTot[1]) begin
                        rxState_q <= asr_pkg::RX_BITS;
                        noise_q <= (lowTot != 2'h3);
                    end else begin
                        rxState_q <= asr_pkg::RX_IDLE;
                    end
                end
            end
            asr_pkg::RX_BITS: begin
                if (edgeSeen) begin
                    // edge past mid-bit belongs to the next bit
                    rt_q <= 4'h0;
                    if (rt_q >= `ASR_RT8) begin
                        bitIdx_q <= bitIdx_q + 4'h1;
                    end
                end else begin
                    rt_q <= rt_q + 4'h1;
                    if (rt_q == `ASR_RT16) begin
                        bitIdx_q <= bitIdx_q + 4'h1;
                    end
                end
                if ((rt_q == `ASR_RT8) || (rt_q == `ASR_RT9)) begin
                    onesCnt_q <= onesTot;
                end
                if (rt_q == `ASR_RT10) begin
                    onesCnt_q <= 2'h0;
                    if (disagree || ((bitIdx_q == 4'h0) && majority)) begin
                        noise_q <= 1'b1;
                    end
                    // start bit value is ignored here once validated
                    if ((bitIdx_q != 4'h0) && (bitIdx_q != lastIdx)) begin
                        rxShift_q <= {majority, rxShift_q[8:1]};
                    end
                    if (bitIdx_q == lastIdx) begin
                        rxState_q <= asr_pkg::RX_IDLE;
                    end
                end
            end
            default: begin
                rxState_q <= asr_pkg::RX_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// receive buffer and flags

logic rxNinth_q;
logic rxFull_q;
logic overrun_q;
logic glitch_q;
logic frameBad_q;
logic statSeen_q;
logic clearSeq;

assign clearSeq = rdData & statSeen_q;

always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
        rxData_q <= 8'h00;
        rxNinth_q <= 1'b0;
        rxFull_q <= 1'b0;
        overrun_q <= 1'b0;
        glitch_q <= 1'b0;
        frameBad_q <= 1'b0;
        statSeen_q <= 1'b0;
    end else begin
        if (rdStat) begin
            statSeen_q <= rxFull_q | overrun_q | glitch_q | frameBad_q;
        end
        if (clearSeq) begin
            rxFull_q <= 1'b0;
            overrun_q <= 1'b0;
            glitch_q <= 1'b0;
            frameBad_q <= 1'b0;
            statSeen_q <= 1'b0;
        end
        // a clear in the same cycle loses against the new character
        if (rxDone && (!frameBad_q || clearSeq)) begin
            if (rxFull_q && !clearSeq) begin
                overrun_q <= 1'b1;
            end else begin
                rxData_q <= frameData;
                rxNinth_q <= frameNinth;
                rxFull_q <= 1'b1;
                glitch_q <= noise_q | disagree;
                frameBad_q <= stopLow;
            end
        end
    end
end

always_comb begin
    stat = '0;
    stat.txBufferEmptyFlag = ~txBufFull_q;
    stat.txDoneFlag = txDone_q;
    stat.rxBufferFullFlag = rxFull_q;
    stat.overrunFlag = overrun_q;
    stat.rxGlitchFlag = glitch_q;
    stat.rxFrameBadFlag = frameBad_q;
    stat.rxNinthBit = rxNinth_q;
end

endmodule

`default_nettype wire

// ---- hw/asr_pkg.sv ----
package asr_pkg;

    typedef enum logic [1:0] {TX_OFF, TX_IDLE, TX_SHIFT} asr_tx_state_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asr_rx_state_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic txNinthBit;
        logic nineBit;
        logic txOn;
        logic rxOn;
        logic rsvd0;
        logic breakQueueBit;
    } asr_ctrl_t;

    typedef struct packed {
        logic txBufferEmptyFlag;
        logic txDoneFlag;
        logic rxBufferFullFlag;
        logic rsvd;
        logic overrunFlag;
        logic rxGlitchFlag;
        logic rxFrameBadFlag;
        logic rxNinthBit;
    } asr_stat_t;

endpackage

// ---- verification/asr_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module asr_core_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serialInPin,
    input wire logic serialOutPin,
    input wire logic serialOutEn
);
    logic [11:0] gapQ;
    logic pinQ;
    logic seenQ;
    // saturates so a long idle never wraps into a false boundary
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gapQ <= 12'h000;
            pinQ <= 1'b1;
            seenQ <= 1'b0;
        end else begin
            pinQ <= serialOutPin;
            if (serialOutPin != pinQ) begin
                gapQ <= 12'h000;
                seenQ <= 1'b1;
            end else if (gapQ != 12'hFFF) begin
                gapQ <= gapQ + 12'h001;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence setupS;
        psel && !penable;
    endsequence
    sequence lowHalf;
        !serialOutPin [*8];
    endsequence
    sequence highHalf;
        serialOutPin [*8];
    endsequence
    chk_apb_wait: assert property (setupS ##1 (psel && penable)
        |-> !pready ##1 pready) else $error("pready not after one wait");
    chk_apb_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    // read data only refreshes on reads, so writes are left out
    chk_unmapped_err: assert property (pready && !pwrite && paddr > 8'h0C
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    chk_mapped_ok: assert property (pready && paddr[1:0] == 2'h0
        && paddr <= 8'h0C |-> !pslverr) else $error("mapped refused");
    chk_idle_high: assert property (
        !serialOutEn |-> serialOutPin) else $error("released pin low");
    chk_keep_stop: assert property (
        $fell(serialOutEn) |-> $past(serialOutPin) && $past(serialOutPin, 8))
        else $error("pin released mid frame");
    chk_start_bit: assert property (
        $fell(serialOutPin) |-> lowHalf ##1 lowHalf)
        else $error("start bit short");
    chk_preamble_idle: assert property (
        $rose(serialOutEn) |-> highHalf ##1 highHalf)
        else $error("no idle preamble");
    chk_bit_bound: assert property (
        seenQ && serialOutPin != pinQ && gapQ != 12'hFFF
        |-> gapQ[3:0] == 4'hF) else $error("edge off bit boundary");
endmodule
bind asr_core asr_core_props i_asr_core_props (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .serialInPin(serialInPin),
    .serialOutPin(serialOutPin),
    .serialOutEn(serialOutEn)
);
`default_nettype wire

// ---- verification/asr_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module asr_remote (
    input wire logic clk,
    input wire logic txLine,
    output logic rxLine
);
    logic nine = 1'b0;
    logic prevQ = 1'b1;
    logic [10:0] sh;
    logic [8:0] gotData;
    logic gotStop;
    int gotCnt = 0;
    int lowRun = 0;
    int lowMax = 0;
    initial rxLine = 1'b1;
    always @(posedge clk) begin
        prevQ <= txLine;
        lowRun <= txLine ? 0 : lowRun + 1;
        if (lowRun > lowMax) begin
            lowMax <= lowRun;
        end
    end
    // mid-bit sampling; stop sample leaves half a bit to catch next start
    initial begin
        forever begin
            @(posedge clk);
            if (prevQ && !txLine) begin
                repeat (7) @(posedge clk);
                for (int i = 0; i < (nine ? 11 : 10); i++) begin
                    if (i > 0) begin
                        repeat (16) @(posedge clk);
                    end
                    sh[i] = txLine;
                end
                gotData = nine ? sh[9:1] : {1'b0, sh[8:1]};
                gotStop = nine ? sh[10] : sh[9];
                gotCnt++;
            end
        end
    end
    task automatic send(input logic [8:0] d, input logic stop,
            input int gBit, input int gOfs, input int gLen);
        logic [10:0] fr;
        logic lvl;
        int n;
        n = nine ? 11 : 10;
        fr = nine ? {stop, d, 1'b0} : {1'b0, stop, d[7:0], 1'b0};
        for (int c = 0; c < n * 16 + 32; c++) begin
            @(posedge clk);
            lvl = (c / 16 < n) ? fr[c / 16] : 1'b1;
            if (c / 16 == gBit && c % 16 >= gOfs && c % 16 < gOfs + gLen) begin
                lvl = ~lvl;
            end
            rxLine <= lvl;
        end
    endtask
endmodule
`default_nettype wire

// ---- verification/async_serial_tx_rx_core_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module async_serial_tx_rx_core_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, serialInPin, serialOutPin, serialOutEn;
    logic [31:0] rd;
    logic err;
    logic watch = 1'b0;
    logic dropped = 1'b0;
    int err_total = 0;
    int compares = 0;
    wire txWire;
    // released line is pulled up
    assign txWire = serialOutEn ? serialOutPin : 1'b1;
    initial forever #25 clk = ~clk;
    asr_core i_asr_core (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialInPin(serialInPin),
        .serialOutPin(serialOutPin), .serialOutEn(serialOutEn));
    asr_remote i_asr_remote (.clk(clk), .txLine(txWire),
        .rxLine(serialInPin));
    always @(posedge clk) begin
        if (watch && !serialOutEn) begin
            dropped <= 1'b1;
        end
    end
    ////////////////////////////////////////
    task automatic finish_test();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_ser(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_total++;
            finish_test();
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp_reg(rd, exp);
    endtask
    // status reads only; rx flags must be clear while polling
    task automatic poll(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, 8'h08, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 200);
        if (rd[b] !== 1'b1) begin
            err_total++;
            finish_test();
        end
    endtask
    task automatic wait_rx(input int k);
        int n;
        n = 0;
        while (i_asr_remote.gotCnt < k && n < 4000) begin
            @(posedge clk);
            n++;
        end
        if (n == 4000) begin
            err_total++;
            finish_test();
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        chk(8'h00, 32'h1);
        chk(8'h04, 32'h0);
        chk(8'h08, 32'hC0);
        chk(8'h10, 32'h0);
        cmp_reg({31'h0, err}, 32'h1);
        apb(1'b1, 8'h04, 32'h0C);
        apb(1'b1, 8'h0C, 32'hA5);
        chk(8'h08, 32'h00);
        poll(7);
        apb(1'b1, 8'h0C, 32'h3C);
        wait_rx(1);
        cmp_ser(i_asr_remote.gotData, 9'h0A5);
        cmp_ser({8'h0, i_asr_remote.gotStop}, 9'h1);
        wait_rx(2);
        cmp_ser(i_asr_remote.gotData, 9'h03C);
        poll(6);
        chk(8'h08, 32'hC0);
        apb(1'b1, 8'h04, 32'h3C);
        i_asr_remote.nine <= 1'b1;
        apb(1'b1, 8'h0C, 32'h55);
        wait_rx(3);
        cmp_ser(i_asr_remote.gotData, 9'h155);
        cmp_ser({8'h0, i_asr_remote.gotStop}, 9'h1);
        poll(6);
        apb(1'b1, 8'h04, 32'h0C);
        i_asr_remote.nine <= 1'b0;
        apb(1'b1, 8'h0C, 32'h0F);
        poll(7);
        watch <= 1'b1;
        apb(1'b1, 8'h04, 32'h04);
        apb(1'b1, 8'h04, 32'h0C);
        wait_rx(4);
        cmp_ser(i_asr_remote.gotData, 9'h00F);
        poll(6);
        watch <= 1'b0;
        cmp_ser({8'h0, dropped}, 9'h0);
        apb(1'b1, 8'h0C, 32'hF0);
        poll(7);
        apb(1'b1, 8'h04, 32'h04);
        wait_rx(5);
        cmp_ser(i_asr_remote.gotData, 9'h0F0);
        repeat (32) @(posedge clk);
        cmp_ser({8'h0, serialOutEn}, 9'h0);
        apb(1'b1, 8'h04, 32'h0D);
        apb(1'b1, 8'h04, 32'h0C);
        wait_rx(6);
        poll(6);
        cmp_ser(i_asr_remote.gotData, 9'h000);
        cmp_ser({8'h0, i_asr_remote.gotStop}, 9'h0);
        cmp_ser({8'h0, i_asr_remote.lowMax % 160 == 0}, 9'h1);
        apb(1'b1, 8'h04, 32'h04);
        i_asr_remote.send(9'h03A, 1'b1, -1, 0, 0);
        chk(8'h08, 32'hE0);
        apb(1'b1, 8'h08, 32'h00);
        chk(8'h08, 32'hE0);
        chk(8'h0C, 32'h3A);
        chk(8'h08, 32'hC0);
        i_asr_remote.send(9'h011, 1'b1, -1, 0, 0);
        i_asr_remote.send(9'h022, 1'b1, -1, 0, 0);
        chk(8'h08, 32'hE8);
        chk(8'h0C, 32'h11);
        i_asr_remote.send(9'h096, 1'b1, 0, 8, 2);
        chk(8'h08, 32'hE4);
        chk(8'h0C, 32'h96);
        i_asr_remote.send(9'h05A, 1'b0, -1, 0, 0);
        i_asr_remote.send(9'h033, 1'b1, -1, 0, 0);
        chk(8'h08, 32'hE2);
        chk(8'h0C, 32'h5A);
        i_asr_remote.send(9'h000, 1'b0, -1, 0, 0);
        chk(8'h08, 32'hE2);
        chk(8'h0C, 32'h00);
        chk(8'h08, 32'hC0);
        finish_test();
    end
endmodule
`default_nettype wire
